// *** hdl/aps_pkg.sv ***
// Constants and types for the amplifier protection supervisor
package aps_pkg;
  localparam int APS_CLK_HZ = 40000000;
  localparam int APS_RETRY_MS = 50;
  localparam int APS_RETRY_CYC = APS_CLK_HZ / 1000 * APS_RETRY_MS;
  localparam int APS_NCH = 2;
  // Register map (byte addresses on the plain register port)
  localparam logic [3:0] APS_REG_CTRL = 4'h0;
  localparam logic [3:0] APS_REG_STAT = 4'h4;
  localparam logic [3:0] APS_REG_CHST = 4'h8;
  // Control register fields
  localparam int APS_CTRL_FAULT_INDICATOR_PIN_MASK = 0;
  localparam int APS_CTRL_SD_MASK = 1;
  localparam int APS_CTRL_RUN = 2;
  // Status register fields
  localparam int APS_STAT_OFFSET = 0;
  localparam int APS_STAT_OTP = 1;
  localparam int APS_STAT_FOLD = 2;
  localparam int APS_STAT_UV = 3;
  localparam int APS_STAT_OV = 4;
  localparam int APS_STAT_OFF_LATCH = 5;
  localparam logic [2:0] APS_CTRL_RST = 3'h0;
  typedef enum logic [1:0] {
    APS_CH_OFF = 2'b00,
    APS_CH_WINDOW = 2'b01,
    APS_CH_RUN = 2'b10,
    APS_CH_RETRY = 2'b11
  } aps_ch_state_t;
endpackage : aps_pkg

// *** hdl/aps_channel.sv ***
// One amplifier channel: window check, short shutdown and retry timing
`timescale 1ns/1ps
`default_nettype none
module aps_channel
  import aps_pkg::*;
#(
  parameter int RETRY_CYC = APS_RETRY_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic allow,
  input wire logic load_short,
  input wire logic supply_short,
  input wire logic out_open,
  output logic stage_en,
  output logic short_flag,
  output aps_ch_state_t state
);
  localparam int CW = $clog2(RETRY_CYC + 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  localparam logic [CW-1:0] CNT_LOAD = CW'(RETRY_CYC - 1);
  aps_ch_state_t st_r;
  logic [CW-1:0] cnt_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= APS_CH_OFF;
      cnt_r <= '0;
    end else if (!allow) begin
      st_r <= APS_CH_OFF;
      cnt_r <= '0;
    end else begin
      case (st_r)
        APS_CH_OFF: begin
          st_r <= APS_CH_WINDOW;
        end
        // Stages stay off until outputs read open
        APS_CH_WINDOW: begin
          if (out_open && !supply_short) begin
            st_r <= APS_CH_RUN;
          end
        end
        APS_CH_RUN: begin
          if (load_short || supply_short) begin
            st_r <= APS_CH_RETRY;
            cnt_r <= CNT_LOAD;
          end
        end
        APS_CH_RETRY: begin
          if (cnt_r <= CNT_ONE) begin
            st_r <= APS_CH_WINDOW;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        default: begin
          st_r <= APS_CH_OFF;
        end
      endcase
    end
  end

  assign stage_en = (st_r == APS_CH_RUN);
  assign short_flag = (st_r == APS_CH_RETRY) || (st_r == APS_CH_RUN && (load_short || supply_short));
  assign state = st_r;
endmodule : aps_channel
`default_nettype wire

// *** hdl/aps_supervisor.sv ***
// Protection supervisor for a two-channel switching amplifier
`timescale 1ns/1ps
`default_nettype none
module aps_supervisor
  import aps_pkg::*;
#(
  parameter int NCH = APS_NCH,
  parameter int RETRY_CYC = APS_RETRY_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic bus_mode,
  input wire logic amp_enable,
  input wire logic offset_filter_grounded,
  input wire logic temp_fold,
  input wire logic temp_over,
  input wire logic overcurrent,
  input wire logic offset_trip,
  input wire logic supply_low,
  input wire logic supply_high,
  input wire logic [NCH-1:0] load_short,
  input wire logic [NCH-1:0] supply_short,
  input wire logic [NCH-1:0] out_open,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [NCH-1:0] stage_en_r,
  output logic mute_r,
  output logic gain_reduce_r,
  output logic current_limit_r,
  output logic fault_indicator_pin_o,
  output logic fault_indicator_pin_oe
);
  logic fault_indicator_pin_mask_r;
  logic sd_mask_r;
  logic run_r;
  logic offset_latch_r;
  logic offset_alarm_r;
  logic enable_d_r;
  logic uv_hold;
  logic temp_shut;
  logic volt_shut;
  logic host_hold;
  logic enable_fall;
  logic offset_clear;
  logic stat_read;
  logic ctrl_write;
  logic pull_short;
  logic pull_supply;
  logic pull_thermal;
  logic pull_offset;
  logic pin_pull_nxt;
  logic [NCH-1:0] ch_pull;
  logic [NCH-1:0] stage_nxt;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] chst_word;
  logic [NCH-1:0] ch_en;
  logic [NCH-1:0] ch_short;
  logic [NCH-1:0] ch_allow;
  logic global_ok;
  logic guard_active;
  logic offset_fault_indicator_pin;
  logic offset_sd;
  logic short_any;
  logic [31:0] rdata_nxt;

  // Guard is off when its filter pin is strapped low
  assign guard_active = !offset_filter_grounded && offset_trip;
  assign offset_sd = guard_active && (!bus_mode || !sd_mask_r);
  assign offset_fault_indicator_pin = guard_active && (!bus_mode || !fault_indicator_pin_mask_r);

  // Falling enable pin is one of two ways out of the latch
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_d_r <= 1'b0;
    end else begin
      enable_d_r <= amp_enable;
    end
  end

  assign enable_fall = enable_d_r && !amp_enable;
  assign offset_clear = enable_fall || offset_filter_grounded;

  // Offset shutdown holds until enable falls or guard disabled
  // A trip in the same cycle as a clear keeps the latch set
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_latch_r <= 1'b0;
    end else if (offset_sd) begin
      offset_latch_r <= 1'b1;
    end else if (offset_clear) begin
      offset_latch_r <= 1'b0;
    end
  end

  assign stat_read = reg_rd && (reg_addr == APS_REG_STAT);
  assign ctrl_write = reg_wr && (reg_addr == APS_REG_CTRL);

  // Alarm bit is sticky; read clears, but a new trip wins
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      offset_alarm_r <= 1'b0;
    end else if (guard_active && bus_mode) begin
      offset_alarm_r <= 1'b1;
    end else if (stat_read) begin
      offset_alarm_r <= 1'b0;
    end
  end

  // Diagnostic mask: in bus mode a masked offset trip leaves the pin alone
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_indicator_pin_mask_r <= APS_CTRL_RST[APS_CTRL_FAULT_INDICATOR_PIN_MASK];
    end else if (ctrl_write) begin
      fault_indicator_pin_mask_r <= reg_wdata[APS_CTRL_FAULT_INDICATOR_PIN_MASK];
    end
  end

  // Shutdown mask: in bus mode a masked offset trip keeps both channels up
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sd_mask_r <= APS_CTRL_RST[APS_CTRL_SD_MASK];
    end else if (ctrl_write) begin
      sd_mask_r <= reg_wdata[APS_CTRL_SD_MASK];
    end
  end

  // Run bit resets to zero, so bus mode needs a host command after reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_r <= APS_CTRL_RST[APS_CTRL_RUN];
    end else if (ctrl_write) begin
      run_r <= reg_wdata[APS_CTRL_RUN];
    end
  end

  // Whole-device shutdown causes; all but offset self-clear
  assign temp_shut = temp_over;
  assign volt_shut = supply_high || uv_hold;

  // Bus mode holds the stages until the host sets the run bit
  assign host_hold = bus_mode && !run_r;

  // Besides the bus-mode run hold, the offset latch is the only cause that needs an outside clear
  assign global_ok = amp_enable && !host_hold && !temp_shut && !volt_shut
    && !offset_latch_r && !offset_sd;

  // Undervoltage sequence: mute first, then stop, then wait for the supply
  typedef enum logic [1:0] {
    APS_UV_RUN = 2'b00,
    APS_UV_MUTE = 2'b01,
    APS_UV_STOP = 2'b10
  } aps_uv_state_t;
  aps_uv_state_t uv_st_r;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      uv_st_r <= APS_UV_RUN;
    end else begin
      case (uv_st_r)
        APS_UV_RUN: begin
          if (supply_low) begin
            uv_st_r <= APS_UV_MUTE;
          end
        end
        // Stages stay up for this one cycle while mute already stands
        APS_UV_MUTE: begin
          uv_st_r <= APS_UV_STOP;
        end
        // Restart needs nothing from the host, only a good supply
        APS_UV_STOP: begin
          if (!supply_low) begin
            uv_st_r <= APS_UV_RUN;
          end
        end
        default: begin
          uv_st_r <= APS_UV_RUN;
        end
      endcase
    end
  end

  assign uv_hold = (uv_st_r != APS_UV_RUN);

  // Mute rises at once on undervoltage, ahead of the stage shutdown
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mute_r <= 1'b1;
    end else begin
      mute_r <= supply_low || !global_ok;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // Every channel sees the same device-wide permission
      assign ch_allow[g] = global_ok;
      // Any short on this channel, live or being retried
      assign ch_pull[g] = ch_short[g] || load_short[g] || supply_short[g];
      aps_channel #(
        .RETRY_CYC(RETRY_CYC)
      ) u_ch (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .allow(ch_allow[g]),
        .load_short(load_short[g]),
        .supply_short(supply_short[g]),
        .out_open(out_open[g]),
        .stage_en(ch_en[g]),
        .short_flag(ch_short[g]),
        .state()
      );
    end
  endgenerate

  assign short_any = |ch_pull;

  // Stages follow the channel machines only while the device may run
  assign stage_nxt = ch_en & {NCH{global_ok}};

  // Flopped so the stage enables never glitch on a combinational path
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_en_r <= '0;
    end else begin
      stage_en_r <= stage_nxt;
    end
  end

  // Gain foldback keeps switching; shutdown is left to the higher trip
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gain_reduce_r <= 1'b0;
    end else begin
      gain_reduce_r <= temp_fold;
    end
  end

  // Current limiting never touches the stage enables
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      current_limit_r <= 1'b0;
    end else begin
      current_limit_r <= overcurrent;
    end
  end

  // Open drain: the pin only ever pulls low, so its data bit is fixed
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_indicator_pin_o <= 1'b0;
    end else begin
      fault_indicator_pin_o <= 1'b0;
    end
  end

  // Pin follows the live faults and each channel's retry wait, and is released once both have cleared
  assign pull_short = short_any;
  assign pull_supply = supply_low || supply_high;
  assign pull_thermal = temp_over || overcurrent;
  assign pull_offset = offset_fault_indicator_pin;
  assign pin_pull_nxt = pull_short || pull_supply || pull_thermal || pull_offset;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_indicator_pin_oe <= 1'b0;
    end else begin
      fault_indicator_pin_oe <= pin_pull_nxt;
    end
  end

  // Control bits read back where they were written
  always_comb begin
    ctrl_word = '0;
    ctrl_word[APS_CTRL_FAULT_INDICATOR_PIN_MASK] = fault_indicator_pin_mask_r;
    ctrl_word[APS_CTRL_SD_MASK] = sd_mask_r;
    ctrl_word[APS_CTRL_RUN] = run_r;
  end

  // Live fault levels beside the two sticky bits
  always_comb begin
    stat_word = '0;
    stat_word[APS_STAT_OFFSET] = offset_alarm_r;
    stat_word[APS_STAT_OTP] = temp_over;
    stat_word[APS_STAT_FOLD] = temp_fold;
    stat_word[APS_STAT_UV] = supply_low;
    stat_word[APS_STAT_OV] = supply_high;
    stat_word[APS_STAT_OFF_LATCH] = offset_latch_r;
  end

  // Running and short/retry flags per channel
  always_comb begin
    chst_word = '0;
    chst_word[NCH-1:0] = ch_en;
    chst_word[2*NCH-1:NCH] = ch_short;
  end

  // Unmapped addresses read as zero
  always_comb begin
    rdata_nxt = '0;
    if (reg_addr == APS_REG_CTRL) begin
      rdata_nxt = ctrl_word;
    end else if (reg_addr == APS_REG_STAT) begin
      rdata_nxt = stat_word;
    end else if (reg_addr == APS_REG_CHST) begin
      rdata_nxt = chst_word;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : aps_supervisor
`default_nettype wire

// *** sim/aps_assertions.sv ***
// Port checker for the amplifier protection supervisor
`timescale 1ns/1ps
`default_nettype none
module aps_assertions #(
  parameter int NCH = 2
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic bus_mode,
  input wire logic amp_enable,
  input wire logic offset_filter_grounded,
  input wire logic temp_fold,
  input wire logic temp_over,
  input wire logic overcurrent,
  input wire logic offset_trip,
  input wire logic supply_low,
  input wire logic supply_high,
  input wire logic [NCH-1:0] load_short,
  input wire logic [NCH-1:0] supply_short,
  input wire logic [NCH-1:0] out_open,
  input wire logic [NCH-1:0] stage_en_r,
  input wire logic mute_r,
  input wire logic gain_reduce_r,
  input wire logic current_limit_r,
  input wire logic fault_indicator_pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_fold_gain: assert property (temp_fold |=> gain_reduce_r)
    else $error("gain not reduced");
  a_over_stop: assert property (temp_over |-> ##[1:2] stage_en_r == '0)
    else $error("stages on in overtemperature");
  a_oc_limit: assert property (overcurrent |=> current_limit_r)
    else $error("no current limit");
  a_low_mute: assert property (supply_low |-> ##2 (mute_r && stage_en_r == '0))
    else $error("undervoltage not muted and stopped");
  a_uv_mute_first: assert property ($rose(supply_low) && stage_en_r == '1 && amp_enable
    && !temp_over && !supply_high && !offset_trip && !(|load_short) && !(|supply_short)
    |=> (mute_r && stage_en_r != '0))
    else $error("undervoltage stopped before mute");
  a_high_stop: assert property (supply_high |-> ##[1:2] stage_en_r == '0)
    else $error("stages on in overvoltage");
  a_short_fault_indicator_pin: assert property (|load_short |-> ##[1:2] fault_indicator_pin_oe)
    else $error("fault_indicator_pin not pulled on short");
  a_window_first: assert property ($rose(stage_en_r[0]) |-> $past(out_open[0] && !supply_short[0], 2))
    else $error("stage enabled without window pass");
  a_pin_offset: assert property (!bus_mode && offset_trip && !offset_filter_grounded
    |-> ##[1:2] (stage_en_r == '0 && fault_indicator_pin_oe))
    else $error("strapped offset trip not acted on");
  a_offset_held: assert property ((!bus_mode && offset_trip && !offset_filter_grounded)
    ##1 (amp_enable && !offset_filter_grounded) [*8] |-> stage_en_r == '0)
    else $error("offset shutdown not latched");
endmodule : aps_assertions
bind aps_supervisor aps_assertions #(.NCH(NCH)) aps_assertions_inst (.core_clk(core_clk), .rst_b(rst_b),
  .bus_mode(bus_mode), .amp_enable(amp_enable), .offset_filter_grounded(offset_filter_grounded),
  .temp_fold(temp_fold), .temp_over(temp_over), .overcurrent(overcurrent), .offset_trip(offset_trip),
  .supply_low(supply_low), .supply_high(supply_high), .load_short(load_short), .supply_short(supply_short),
  .out_open(out_open), .stage_en_r(stage_en_r), .mute_r(mute_r), .gain_reduce_r(gain_reduce_r),
  .current_limit_r(current_limit_r), .fault_indicator_pin_oe(fault_indicator_pin_oe));
`default_nettype wire

// *** sim/aps_stage_model.sv ***
// Far-side model of the power stage outputs as the window check sees them
`timescale 1ns/1ps
`default_nettype none
module aps_stage_model (
  input wire logic [1:0] stage_en,
  input wire logic [1:0] inj_supply,
  output logic [1:0] out_open
);
  // Switching or rail-shorted outputs never read as open
  assign out_open = ~inj_supply & ~stage_en;
endmodule : aps_stage_model
`default_nettype wire

// *** sim/aps_supervisor_test.sv ***
// Self-checking bench for the amplifier protection supervisor
`timescale 1ns/1ps
`default_nettype none
module aps_supervisor_test;
  import aps_pkg::*;
  localparam int RC = 20;
  typedef struct {logic [4:0] s; logic [1:0] st; logic g; logic c; logic m;} aps_row_t;
  aps_row_t rows [5] = '{'{5'h01, 2'h3, 1'h1, 1'h0, 1'h0}, '{5'h02, 2'h0, 1'h0, 1'h0, 1'h1},
    '{5'h04, 2'h3, 1'h0, 1'h1, 1'h0}, '{5'h08, 2'h0, 1'h0, 1'h0, 1'h1}, '{5'h10, 2'h0, 1'h0, 1'h0, 1'h1}};
  logic core_clk = 1'h0, rst_b = 1'h0, bus_mode = 1'h0, amp_enable = 1'h1;
  logic offset_filter_grounded = 1'h0, offset_trip = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic mute_r, gain_reduce_r, current_limit_r, fdoe, fdo;
  logic [4:0] sens = 5'h00;
  logic [1:0] load_short = 2'h0, supply_short = 2'h0, out_open, stage_en_r;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  int errors = 0, n_compared = 0, i, n;
  aps_supervisor #(.RETRY_CYC(RC)) aps_supervisor_inst (.core_clk(core_clk), .rst_b(rst_b),
    .bus_mode(bus_mode), .amp_enable(amp_enable), .offset_filter_grounded(offset_filter_grounded),
    .temp_fold(sens[0]), .temp_over(sens[1]), .overcurrent(sens[2]), .offset_trip(offset_trip),
    .supply_low(sens[3]), .supply_high(sens[4]), .load_short(load_short), .supply_short(supply_short),
    .out_open(out_open), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stage_en_r(stage_en_r), .mute_r(mute_r), .gain_reduce_r(gain_reduce_r),
    .current_limit_r(current_limit_r), .fault_indicator_pin_o(fdo), .fault_indicator_pin_oe(fdoe));
  aps_stage_model aps_stage_model_inst (.stage_en(stage_en_r), .inj_supply(supply_short), .out_open(out_open));
  initial forever #12.5 core_clk = ~core_clk;
  task end_sim();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Outputs are sampled at the falling edge, away from the driving edge
  task wt(input logic [1:0] e, input int lim);
    int k;
    for (k = 0; k < lim && stage_en_r !== e; k++) @(negedge core_clk);
    chk("stage_wait", 32'(e), 32'(stage_en_r));
    if (stage_en_r !== e) end_sim();
  endtask : wt
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    @(negedge core_clk);
    chk("rdata", e, reg_rdata);
  endtask : rd
  task pulse_trip();
    @(posedge core_clk);
    offset_trip <= 1'h1;
    @(posedge core_clk);
    offset_trip <= 1'h0;
  endtask : pulse_trip
  task toggle_en();
    @(posedge core_clk);
    amp_enable <= 1'h0;
    @(posedge core_clk);
    amp_enable <= 1'h1;
  endtask : toggle_en
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'h1;
    wt(2'h3, 20);
    for (i = 0; i < 5; i++) begin
      @(posedge core_clk);
      sens <= rows[i].s;
      repeat (4) @(negedge core_clk);
      chk("stage", 32'(rows[i].st), 32'(stage_en_r));
      chk("gain", 32'(rows[i].g), 32'(gain_reduce_r));
      chk("limit", 32'(rows[i].c), 32'(current_limit_r));
      chk("mute", 32'(rows[i].m), 32'(mute_r));
      @(posedge core_clk);
      sens <= 5'h00;
      wt(2'h3, 12);
    end
    @(posedge core_clk);
    load_short <= 2'h1;
    wt(2'h2, 6);
    chk("fault_indicator_pin", 32'h1, 32'(fdoe));
    chk("fault_indicator_pin_level", 32'h0, 32'(fdo));
    for (n = 0; n < 3 * RC && stage_en_r[0] !== 1'h1; n++) @(negedge core_clk);
    chk("retry_gap", 32'h1, 32'(n >= RC && n <= RC + 6));
    wt(2'h2, 6);
    @(posedge core_clk);
    load_short <= 2'h0;
    wt(2'h3, RC + 10);
    @(posedge core_clk);
    supply_short <= 2'h2;
    wt(2'h1, 6);
    repeat (3 * RC) @(negedge core_clk);
    chk("held_off", 32'h1, 32'(stage_en_r));
    @(posedge core_clk);
    supply_short <= 2'h0;
    wt(2'h3, RC + 10);
    pulse_trip();
    wt(2'h0, 4);
    repeat (20) @(negedge core_clk);
    chk("latched", 32'h0, 32'(stage_en_r));
    toggle_en();
    wt(2'h3, 10);
    @(posedge core_clk);
    offset_filter_grounded <= 1'h1;
    pulse_trip();
    repeat (4) @(negedge core_clk);
    chk("guard_off", 32'h3, 32'(stage_en_r));
    @(posedge core_clk);
    offset_filter_grounded <= 1'h0;
    rst_b <= 1'h0;
    bus_mode <= 1'h1;
    supply_short <= 2'h1;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'h1;
    rd(APS_REG_CTRL, 32'(APS_CTRL_RST));
    repeat (10) @(negedge core_clk);
    chk("no_autorun", 32'h0, 32'(stage_en_r));
    wr(APS_REG_CTRL, 32'h4);
    wt(2'h2, 10);
    repeat (10) @(negedge core_clk);
    chk("start_halt", 32'h2, 32'(stage_en_r));
    @(posedge core_clk);
    supply_short <= 2'h0;
    wt(2'h3, 10);
    pulse_trip();
    wt(2'h0, 4);
    rd(APS_REG_STAT, 32'h21);
    rd(APS_REG_STAT, 32'h20);
    rd(4'hC, 32'h0);
    toggle_en();
    wt(2'h3, 10);
    wr(APS_REG_CTRL, 32'h7);
    pulse_trip();
    repeat (4) @(negedge core_clk);
    chk("masked_sd", 32'h3, 32'(stage_en_r));
    chk("masked_fault_indicator_pin", 32'h0, 32'(fdoe));
    rd(APS_REG_STAT, 32'h1);
    end_sim();
  end
endmodule : aps_supervisor_test
`default_nettype wire
